// ==== core/gprb_defs.vh ====
`ifndef GPRB_DEFS_VH
`define GPRB_DEFS_VH

// Global window and register offsets
`define GPRB_GLOBAL_LIMIT 8'h10
`define GPRB_OFS_RESET_PART 4'h0
`define GPRB_OFS_PAGE_SEL 4'h1
`define GPRB_OFS_CONV_FAULT 4'h2
`define GPRB_OFS_LREG_FAULT 4'h3
`define GPRB_OFS_LREG_EN 4'h4
`define GPRB_OFS_CONV_EN 4'h5
// Microcontroller base of the global window
`define GPRB_MCU_BASE 16'hA000
`define GPRB_MCU_BASE_HI 12'hA00
// Field positions
`define GPRB_MASTER_RESET_BIT 7
`define GPRB_PAGE_MSB 1
`define GPRB_CONV_FAULT_MSB 3
`define GPRB_LREG_MSB 6
// Reset values
`define GPRB_PAGE_RST 2'h0
`define GPRB_LREG_EN_RST 7'h00
`define GPRB_CONV_EN_RST 8'h00
// Length of the self-triggered system reset pulse, in cycles
`define GPRB_SYS_RESET_CYCLES 4'h8

`endif

// ==== core/gprb_arbiter.v ====
`timescale 1ns/100ps
// Byte-wise arbiter: serial slave side always wins a collision
module gprb_arbiter (
    input wire i2c_req,
    input wire i2c_we,
    input wire [7:0] i2c_addr,
    input wire [7:0] i2c_wdata,
    input wire mcu_req,
    input wire mcu_we,
    input wire [7:0] mcu_addr,
    input wire [7:0] mcu_wdata,
    output reg grant_i2c,
    output reg grant_mcu,
    output reg acc_valid,
    output reg acc_we,
    output reg [7:0] acc_addr,
    output reg [7:0] acc_wdata
);

    // Strict priority, one byte per grant
    always @*
    begin
        grant_i2c = i2c_req;
        grant_mcu = mcu_req & ~i2c_req;
        acc_valid = i2c_req | mcu_req;
        acc_we = i2c_req ? i2c_we : mcu_we;
        acc_addr = i2c_req ? i2c_addr : mcu_addr;
        acc_wdata = i2c_req ? i2c_wdata : mcu_wdata;
    end

endmodule

// ==== core/gprb_sync.v ====
`timescale 1ns/100ps
// Two-stage synchroniser for a bus of pin levels
module gprb_sync #(
    parameter WIDTH = 8
) (
    input wire clk,
    input wire sys_rst,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);

    reg [WIDTH-1:0] meta_reg;

    // First stage feeds only the second
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta_reg <= {WIDTH{1'b0}};
            dout <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end

endmodule

// ==== core/gprb_global_regs.v ====
`timescale 1ns/100ps
`include "gprb_defs.vh"
module gprb_global_regs #(
    parameter [6:0] PART_CODE = 7'h2C, // Arbitrary value
    parameter [3:0] SYS_RESET_CYCLES = `GPRB_SYS_RESET_CYCLES
) (
    input wire clk,
    input wire sys_rst,
    input wire i2c_req,
    input wire i2c_we,
    input wire [7:0] i2c_offset,
    input wire [7:0] i2c_wdata,
    input wire mcu_req,
    input wire mcu_we,
    input wire [15:0] mcu_addr,
    input wire [7:0] mcu_wdata,
    input wire [3:0] conv_fault_pin,
    input wire [6:0] lreg_fault_pin,
    input wire [7:0] page_rdata,
    output reg i2c_ack,
    output reg [7:0] i2c_rdata,
    output reg mcu_ack,
    output reg [7:0] mcu_rdata,
    output reg page_req,
    output reg page_we,
    output reg [1:0] page_num,
    output reg [7:0] page_offset,
    output reg [7:0] page_wdata,
    output reg [1:0] register_page_select,
    output reg [6:0] linear_regulator_enables,
    output reg [7:0] switching_converter_enables,
    output reg system_reset_req,
    output reg power_off_req
);

    wire grant_i2c;
    wire grant_mcu;
    wire acc_valid;
    wire acc_we;
    wire [7:0] acc_addr;
    wire [7:0] acc_wdata;
    wire [10:0] fault_sync;
    wire mcu_in_window;
    wire i2c_global;
    wire acc_global;
    wire [3:0] acc_ofs;
    reg [7:0] glob_rdata;
    reg [3:0] rst_cnt_reg;
    reg pend_i2c_reg;
    wire [3:0] conv_fault_sync;
    wire [6:0] lreg_fault_sync;
    wire mcu_req_win;
    wire take_i2c_global;
    wire take_i2c_paged;
    wire glob_wr;
    wire wr_reset_part;
    wire wr_page_sel;
    wire wr_lreg_en;
    wire wr_conv_en;
    wire master_reset_wr;
    wire rst_cnt_busy;
    wire [7:0] reset_part_rd;
    wire [7:0] page_sel_rd;
    wire [7:0] conv_fault_rd;
    wire [7:0] lreg_fault_rd;
    wire [7:0] lreg_en_rd;
    wire [7:0] conv_en_rd;

    // Fault pins come from analog blocks, so synchronise them
    gprb_sync #(
        .WIDTH(11)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din({lreg_fault_pin, conv_fault_pin}),
        .dout(fault_sync)
    );

    // Split the synchronised levels by register
    assign conv_fault_sync = fault_sync[`GPRB_CONV_FAULT_MSB:0];
    assign lreg_fault_sync = fault_sync[10:4];

    // Microcontroller side only addresses the 0xA00x global window
    assign mcu_in_window = (mcu_addr[15:4] == `GPRB_MCU_BASE_HI);
    assign mcu_req_win = mcu_req & mcu_in_window;
    // Serial offsets below sixteen are global on any page
    assign i2c_global = (i2c_offset < `GPRB_GLOBAL_LIMIT);

    gprb_arbiter u_arb (
        .i2c_req(i2c_req),
        .i2c_we(i2c_we),
        .i2c_addr(i2c_offset),
        .i2c_wdata(i2c_wdata),
        .mcu_req(mcu_req_win),
        .mcu_we(mcu_we),
        .mcu_addr({4'h0, mcu_addr[3:0]}),
        .mcu_wdata(mcu_wdata),
        .grant_i2c(grant_i2c),
        .grant_mcu(grant_mcu),
        .acc_valid(acc_valid),
        .acc_we(acc_we),
        .acc_addr(acc_addr),
        .acc_wdata(acc_wdata)
    );

    assign acc_global = grant_i2c ? i2c_global : 1'b1;
    assign acc_ofs = acc_addr[3:0];

    // Read values of each global register; reserved bits read zero
    assign reset_part_rd = {1'b0, PART_CODE};
    assign page_sel_rd = {6'h00, register_page_select};
    assign conv_fault_rd = {4'h0, conv_fault_sync};
    assign lreg_fault_rd = {1'b0, lreg_fault_sync};
    assign lreg_en_rd = {1'b0, linear_regulator_enables};
    assign conv_en_rd = switching_converter_enables;

    // Read mux over the shared global set
    always @*
    begin
        case (acc_ofs)
            `GPRB_OFS_RESET_PART: glob_rdata = reset_part_rd;
            `GPRB_OFS_PAGE_SEL: glob_rdata = page_sel_rd;
            `GPRB_OFS_CONV_FAULT: glob_rdata = conv_fault_rd;
            `GPRB_OFS_LREG_FAULT: glob_rdata = lreg_fault_rd;
            `GPRB_OFS_LREG_EN: glob_rdata = lreg_en_rd;
            `GPRB_OFS_CONV_EN: glob_rdata = conv_en_rd;
            default: glob_rdata = 8'h00;
        endcase
    end

    // A held paged request is taken once and then waits for its answer
    assign take_i2c_global = grant_i2c & i2c_global;
    assign take_i2c_paged = grant_i2c & ~i2c_global & ~pend_i2c_reg;

    // Write strobes of the writable global registers
    assign glob_wr = acc_valid & acc_global & acc_we;
    assign wr_reset_part = glob_wr & (acc_ofs == `GPRB_OFS_RESET_PART);
    assign wr_page_sel = glob_wr & (acc_ofs == `GPRB_OFS_PAGE_SEL);
    assign wr_lreg_en = glob_wr & (acc_ofs == `GPRB_OFS_LREG_EN);
    assign wr_conv_en = glob_wr & (acc_ofs == `GPRB_OFS_CONV_EN);

    // Page selector, two bits wide
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            register_page_select <= `GPRB_PAGE_RST;
        end
        else if (wr_page_sel)
        begin
            register_page_select <= acc_wdata[`GPRB_PAGE_MSB:0];
        end
    end

    // Linear regulator enables, reserved top bit dropped
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            linear_regulator_enables <= `GPRB_LREG_EN_RST;
        end
        else if (wr_lreg_en)
        begin
            linear_regulator_enables <= acc_wdata[`GPRB_LREG_MSB:0];
        end
    end

    // Switching converter enables, full byte
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            switching_converter_enables <= `GPRB_CONV_EN_RST;
        end
        else if (wr_conv_en)
        begin
            switching_converter_enables <= acc_wdata;
        end
    end

    // Serial answers: global at once, paged one cycle later
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            i2c_ack <= 1'b0;
            i2c_rdata <= 8'h00;
            pend_i2c_reg <= 1'b0;
        end
        else
        begin
            i2c_ack <= pend_i2c_reg | take_i2c_global;
            pend_i2c_reg <= take_i2c_paged;
            if (take_i2c_global)
            begin
                i2c_rdata <= glob_rdata;
            end
            else if (pend_i2c_reg)
            begin
                i2c_rdata <= page_rdata;
            end
        end
    end

    // Paged access goes to the page chosen by the selector
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            page_req <= 1'b0;
            page_we <= 1'b0;
            page_num <= 2'h0;
            page_offset <= 8'h00;
            page_wdata <= 8'h00;
        end
        else
        begin
            page_req <= take_i2c_paged;
            if (take_i2c_paged)
            begin
                page_we <= acc_we;
                page_num <= register_page_select;
                page_offset <= acc_addr;
                page_wdata <= acc_wdata;
            end
        end
    end

    // Microcontroller answers only while the serial side is idle
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mcu_ack <= 1'b0;
            mcu_rdata <= 8'h00;
        end
        else
        begin
            mcu_ack <= grant_mcu;
            if (grant_mcu)
            begin
                mcu_rdata <= glob_rdata;
            end
        end
    end

    // Master reset: only a written one in bit 7 loads the pulse counter
    assign master_reset_wr = wr_reset_part & acc_wdata[`GPRB_MASTER_RESET_BIT];
    assign rst_cnt_busy = (rst_cnt_reg != 4'h0);

    // Pulse length counter; the system reset clears it too
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rst_cnt_reg <= 4'h0;
        end
        else if (rst_cnt_busy)
        begin
            rst_cnt_reg <= rst_cnt_reg - 4'h1;
        end
        else if (master_reset_wr)
        begin
            rst_cnt_reg <= SYS_RESET_CYCLES;
        end
    end

    // Stretched system reset request
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            system_reset_req <= 1'b0;
        end
        else
        begin
            system_reset_req <= rst_cnt_busy;
        end
    end

    // OFF request stays until the system reset clears it
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            power_off_req <= 1'b0;
        end
        else if (rst_cnt_busy)
        begin
            power_off_req <= 1'b1;
        end
    end

endmodule

// ==== tb/gprb_page_model.sv ====
`timescale 1ns/100ps
// Paged register space behind the global window
module gprb_page_model (
    input logic clk,
    input logic page_req,
    input logic page_we,
    input logic [1:0] page_num,
    input logic [7:0] page_offset,
    input logic [7:0] page_wdata,
    output logic [7:0] page_rdata
);
    logic [7:0] mem [0:1023];
    initial page_rdata = 8'h00;
    // Data shows at the falling edge within the request cycle, then scrambles
    always @(negedge clk)
        page_rdata <= page_req ? mem[{page_num, page_offset}] : ~page_rdata;
    // Writes land on the request edge
    always @(posedge clk)
        if (page_req && page_we)
            mem[{page_num, page_offset}] <= page_wdata;
endmodule

// ==== tb/gprb_global_regs_monitor.sv ====
`timescale 1ns/100ps
// Port checks on the global register bank
module gprb_global_regs_monitor (
    input logic clk,
    input logic sys_rst,
    input logic i2c_req,
    input logic i2c_we,
    input logic [7:0] i2c_offset,
    input logic [7:0] i2c_wdata,
    input logic mcu_req,
    input logic [15:0] mcu_addr,
    input logic [7:0] page_rdata,
    input logic i2c_ack,
    input logic [7:0] i2c_rdata,
    input logic mcu_ack,
    input logic page_req,
    input logic page_we,
    input logic [1:0] page_num,
    input logic [1:0] register_page_select,
    input logic system_reset_req,
    input logic power_off_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Master reset write and the pulse it causes
    sequence wr_s(b);
        $rose(i2c_req) && i2c_we && i2c_offset == 8'h00 && i2c_wdata[7] == b;
    endsequence
    sequence pulse_s;
        (system_reset_req && power_off_req) [*8] ##1 !system_reset_req;
    endsequence
    global_ack_a: assert property ($rose(i2c_req) && i2c_offset < 8'h10 |=> i2c_ack)
        else $error("global ack late");
    page_fwd_a: assert property ($rose(i2c_req) && i2c_offset >= 8'h10 |=>
        page_req && page_num == register_page_select ##1 i2c_ack) else $error("paged fwd");
    page_data_a: assert property (page_req && !page_we |=> i2c_rdata == $past(page_rdata))
        else $error("paged data");
    serial_first_a: assert property (i2c_req |=> !mcu_ack)
        else $error("mcu not stalled");
    mcu_ack_a: assert property ($rose(mcu_req) && !i2c_req && mcu_addr[15:4] == 12'hA00 |=> mcu_ack)
        else $error("mcu ack late");
    reset_pulse_a: assert property (wr_s(1'b1) |=> ##1 pulse_s)
        else $error("reset pulse");
    no_reset_a: assert property (wr_s(1'b0) and !system_reset_req |=> ##1 !system_reset_req)
        else $error("spurious reset");
    off_hold_a: assert property (power_off_req |=> power_off_req)
        else $error("off state lost");
    page_once_a: assert property (page_req |=> !page_req)
        else $error("paged access repeated");
    mcu_window_a: assert property (mcu_addr[15:4] != 12'hA00 |=> !mcu_ack)
        else $error("mcu outside window answered");
endmodule
bind gprb_global_regs gprb_global_regs_monitor i_monitor (.*);

// ==== tb/global_page_register_bank_tb.sv ====
`timescale 1ns/100ps
module global_page_register_bank_tb;
    localparam logic [6:0] CODE = 7'h3B; // Arbitrary value
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic i2c_req = 1'b0, i2c_we = 1'b0, mcu_req = 1'b0, mcu_we = 1'b0;
    logic [7:0] i2c_offset = 8'h00, i2c_wdata = 8'h00, mcu_wdata = 8'h00, page_rdata;
    logic [15:0] mcu_addr = 16'h0000;
    logic [3:0] conv_fault_pin = 4'h0;
    logic [6:0] lreg_fault_pin = 7'h00, linear_regulator_enables;
    logic i2c_ack, mcu_ack, page_req, page_we, system_reset_req, power_off_req;
    logic [7:0] i2c_rdata, mcu_rdata, page_offset, page_wdata, switching_converter_enables;
    logic [1:0] page_num, register_page_select;
    logic [15:0] qi[$], qm[$];
    logic [7:0] v, pv[3];
    int miscompares = 0, total_checks = 0;

    always #2 clk = ~clk;

    gprb_global_regs #(.PART_CODE(CODE)) i_gprb_global_regs (.*);
    gprb_page_model i_gprb_page_model (.*);

    // Masked compare of one byte
    task automatic cmp(input logic [15:0] n, input logic [7:0] got);
        total_checks++;
        if ((got & n[15:8]) !== n[7:0])
        begin
            miscompares++;
            $display("[FAIL] %0t got %h want %h", $time, got, n[7:0]);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One byte access, s picks the microcontroller side
    task automatic acc(bit s, bit w, logic [15:0] a, logic [7:0] d, e, m);
        int n;
        if (s) qm.push_back({m, e}); else qi.push_back({m, e});
        @(negedge clk);
        if (s) {mcu_we, mcu_addr, mcu_wdata, mcu_req} = {w, a, d, 1'b1};
        else {i2c_we, i2c_offset, i2c_wdata, i2c_req} = {w, a[7:0], d, 1'b1};
        for (n = 0; n < 30 && (s ? mcu_ack : i2c_ack) !== 1'b1; n++)
            @(negedge clk);
        if (n == 30)
        begin
            miscompares++;
            $display("[FAIL] %0t no answer", $time);
            end_sim();
        end
        if (s) mcu_req = 1'b0; else i2c_req = 1'b0;
    endtask

    // Results are matched against the oldest note
    always @(posedge clk)
    begin
        if (i2c_ack === 1'b1 && qi.size() > 0) cmp(qi.pop_front(), i2c_rdata);
        if (mcu_ack === 1'b1 && qm.size() > 0) cmp(qm.pop_front(), mcu_rdata);
    end

    initial
    begin
        void'($urandom(64298));
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        for (int k = 0; k < 6; k++)
            acc(0, 0, 16'(k), 0, k ? 8'h00 : {1'b0, CODE}, 8'hFF);
        acc(1, 0, 16'hA00A, 0, 8'h00, 8'hFF);
        $display("test reset values done");
        for (int k = 0; k < 3; k++)
        begin
            v = $urandom;
            acc(0, 1, 1, {v[7:2], 2'(k)}, 0, 0);
            acc(1, 0, 16'hA001, 0, 8'(k), 8'hFF);
            acc(0, 1, 4, v, 0, 0);
            acc(1, 0, 16'hA004, 0, {1'b0, v[6:0]}, 8'hFF);
            acc(1, 1, 16'hA005, ~v, 0, 0);
            acc(0, 0, 5, 0, ~v, 8'hFF);
            cmp({8'h03, 6'h00, 2'(k)}, {6'h00, register_page_select});
            cmp({8'h7F, 1'b0, v[6:0]}, {1'b0, linear_regulator_enables});
            cmp({8'hFF, ~v}, switching_converter_enables);
            pv[k] = $urandom;
            acc(0, 1, 8'h40, pv[k], 0, 0);
        end
        for (int k = 0; k < 3; k++)
        begin
            acc(1, 1, 16'hA001, 8'(k), 0, 0);
            acc(0, 0, 8'h40, 0, pv[k], 8'hFF);
        end
        $display("test paging done");
        for (int k = 0; k < 2; k++)
        begin
            conv_fault_pin = $urandom;
            lreg_fault_pin = $urandom;
            repeat (4) @(negedge clk);
            acc(0, 1, 2, 8'hFF, 0, 0);
            acc(0, 0, 2, 0, {4'h0, conv_fault_pin}, 8'hFF);
            acc(1, 0, 16'hA003, 0, {1'b0, lreg_fault_pin}, 8'hFF);
            fork
                acc(0, 0, 3, 0, {1'b0, lreg_fault_pin}, 8'hFF);
                acc(1, 0, 16'hA002, 0, {4'h0, conv_fault_pin}, 8'hFF);
            join
        end
        $display("test faults done");
        acc(0, 1, 0, 8'h7F, 0, 0);
        acc(0, 1, 0, 8'h80, 0, 0);
        for (int n = 0; n < 20 && system_reset_req !== 1'b1; n++) @(negedge clk);
        cmp(16'h0303, {6'h00, system_reset_req, power_off_req});
        for (int n = 0; n < 20 && system_reset_req !== 1'b0; n++) @(negedge clk);
        cmp(16'h0301, {6'h00, system_reset_req, power_off_req});
        sys_rst = 1'b1;
        @(negedge clk);
        sys_rst = 1'b0;
        acc(0, 0, 0, 0, {1'b0, CODE}, 8'hFF);
        acc(0, 0, 1, 0, 8'h00, 8'hFF);
        $display("test master reset done");
        end_sim();
    end
endmodule
